// ==== include/pbs_pkg.sv ====
// Notes on behaviour
// - Enable deasserted at power-up.
// - Turn-on needs 32 ms continuous low.
// - Extra configurable turn-on delay added.
// - Button high restarts any debounce timer.
// - Shutdown request ignored 512 ms after enable.
// - Button ignored during power-on blanking.
// - Request low at blanking end aborts power-on.
// - Interrupt asserts after 32 ms press.
// - Interrupt held 32 ms minimum, tracks button.
// - Request low releases enable immediately.
// - Forced off after 64 ms continuous low.
// - Extra configurable power-down delay added.
// - Long press releases interrupt and enable.
// - 256 ms button lockout after shutdown.
// - Enable polarity is a build option.
package pbs_pkg;
	localparam int unsigned CLK_HZ       = 50_000_000;
	localparam int unsigned TICK_US      = 100;
	localparam int unsigned TICK_CYCLES  = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned TICK_W       = 13;
	localparam int unsigned TICKS_PER_MS = 1000 / TICK_US;
	localparam int unsigned DEB_MS       = 32;
	localparam int unsigned BLANK_MS     = 512;
	localparam int unsigned LOCK_MS      = 256;
	localparam int unsigned PD_MS        = 64;
	localparam int unsigned CNT_W        = 24;
	localparam logic [CNT_W-1:0] DEB_TICKS   = CNT_W'(DEB_MS * TICKS_PER_MS);
	localparam logic [CNT_W-1:0] BLANK_TICKS = CNT_W'(BLANK_MS * TICKS_PER_MS);
	localparam logic [CNT_W-1:0] LOCK_TICKS  = CNT_W'(LOCK_MS * TICKS_PER_MS);
	localparam logic [CNT_W-1:0] PD_TICKS    = CNT_W'(PD_MS * TICKS_PER_MS);
	localparam logic [1:0]       SYNC_RESET  = 2'h3;

	typedef enum logic [2:0] {
		PBS_OFF   = 3'h0,
		PBS_ARM   = 3'h1,
		PBS_BLANK = 3'h2,
		PBS_RUN   = 3'h3,
		PBS_LOCK  = 3'h4
	} pbs_state_e;
endpackage

// ==== verilog/pbs_tick.sv ====
`timescale 1ns/10ps
module pbs_tick
#(
	parameter int unsigned CYCLES = pbs_pkg::TICK_CYCLES
)
(
	input  wire logic clk,
	input  wire logic rstn,
	output logic      tick
);
	typedef struct packed {
		logic [pbs_pkg::TICK_W-1:0] cnt;
		logic                       tick;
	} pbs_tick_s;

	pbs_tick_s st_reg;
	pbs_tick_s st_next;

	// Fixed timebase for every timer
	always_comb
	begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (st_reg.cnt == pbs_pkg::TICK_W'(CYCLES - 1))
		begin
			st_next.cnt = '0;
			st_next.tick = 1'b1;
		end
		else
			st_next.cnt = st_reg.cnt + 1'b1;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign tick = st_reg.tick;
endmodule // pbs_tick

// ==== verilog/pbs_sequencer.sv ====
`timescale 1ns/10ps
module pbs_sequencer
#(
	parameter bit          EN_ACTIVE_HIGH = 1'b1,
	parameter int unsigned TICK_CYCLES    = pbs_pkg::TICK_CYCLES
)
(
	input  wire logic                    clk,
	input  wire logic                    rstn,
	input  wire logic                    button_in_n,
	input  wire logic                    kill_in_n,
	input  wire logic [pbs_pkg::CNT_W-1:0] on_delay_adjust,
	input  wire logic [pbs_pkg::CNT_W-1:0] off_delay_adjust,
	output logic                         power_en,
	output logic                         int_out_n,
	output logic                         int_oe_n,
	output logic                         power_on_sts
);
	typedef struct packed {
		logic [1:0]                  btn_sync;
		logic [1:0]                  kill_sync;
		pbs_pkg::pbs_state_e         state;
		logic [pbs_pkg::CNT_W-1:0]   low_cnt;
		logic [pbs_pkg::CNT_W-1:0]   tmr;
		logic                        int_act;
		logic                        en_act;
		logic                        en_pin;
		logic                        int_pin_n;
	} pbs_seq_s;

	pbs_seq_s st_reg;
	pbs_seq_s st_next;
	logic     tick;
	logic     btn_low;
	logic     kill_low;

	pbs_tick #(.CYCLES(TICK_CYCLES)) u_tick
	(
		.clk  (clk),
		.rstn (rstn),
		.tick (tick)
	);

	function automatic logic [pbs_pkg::CNT_W-1:0] sat_inc(input logic [pbs_pkg::CNT_W-1:0] v);
		sat_inc = (&v) ? v : v + 1'b1;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Synchronised inputs, second stage only
	assign btn_low  = ~st_reg.btn_sync[1];
	assign kill_low = ~st_reg.kill_sync[1];

	always_comb
	begin
		st_next = st_reg;
		st_next.btn_sync  = {st_reg.btn_sync[0], button_in_n};
		st_next.kill_sync = {st_reg.kill_sync[0], kill_in_n};
		// Continuous-low counter, cleared by any high
		if (!btn_low)
			st_next.low_cnt = '0;
		else if (tick)
			st_next.low_cnt = sat_inc(st_reg.low_cnt);
		if (tick && st_reg.tmr != '0)
			st_next.tmr = st_reg.tmr - 1'b1;
		unique case (st_reg.state)
			pbs_pkg::PBS_OFF:
			begin
				st_next.en_act = 1'b0;
				st_next.int_act = 1'b0;
				if (btn_low)
					st_next.state = pbs_pkg::PBS_ARM;
			end
			pbs_pkg::PBS_ARM:
			begin
				if (!btn_low)
					st_next.state = pbs_pkg::PBS_OFF;
				else if (st_reg.low_cnt >= pbs_pkg::DEB_TICKS + on_delay_adjust)
				begin
					st_next.en_act = 1'b1;
					st_next.tmr = pbs_pkg::BLANK_TICKS;
					st_next.state = pbs_pkg::PBS_BLANK;
				end
			end
			pbs_pkg::PBS_BLANK:
			begin
				// Button ignored here; request checked only when the blanking timer reaches zero
				if (st_reg.tmr == '0)
				begin
					if (kill_low)
					begin
						st_next.en_act = 1'b0;
						st_next.state = pbs_pkg::PBS_OFF;
					end
					else
						st_next.state = pbs_pkg::PBS_RUN;
				end
			end
			pbs_pkg::PBS_RUN:
			begin
				if (st_reg.int_act)
				begin
					if (st_reg.tmr == '0 && !btn_low)
						st_next.int_act = 1'b0;
				end
				else if (btn_low && st_reg.low_cnt >= pbs_pkg::DEB_TICKS)
				begin
					st_next.int_act = 1'b1;
					st_next.tmr = pbs_pkg::DEB_TICKS;
				end
				if (kill_low)
				begin
					st_next.en_act = 1'b0;
					st_next.int_act = 1'b0;
					st_next.tmr = pbs_pkg::LOCK_TICKS;
					st_next.state = pbs_pkg::PBS_LOCK;
				end
				else if (btn_low && st_reg.low_cnt >= pbs_pkg::PD_TICKS + off_delay_adjust)
				begin
					st_next.en_act = 1'b0;
					st_next.int_act = 1'b0;
					st_next.tmr = pbs_pkg::LOCK_TICKS;
					st_next.state = pbs_pkg::PBS_LOCK;
				end
			end
			pbs_pkg::PBS_LOCK:
			begin
				// Button held through lockout must be released first
				if (st_reg.tmr == '0 && !btn_low)
					st_next.state = pbs_pkg::PBS_OFF;
			end
			default:
			begin
				st_next.state = pbs_pkg::PBS_OFF;
				st_next.en_act = 1'b0;
				st_next.int_act = 1'b0;
			end
		endcase
		st_next.en_pin = st_next.en_act ^ ~EN_ACTIVE_HIGH;
		st_next.int_pin_n = ~st_next.int_act;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_reg <= '0;
			st_reg.btn_sync  <= pbs_pkg::SYNC_RESET;
			st_reg.kill_sync <= pbs_pkg::SYNC_RESET;
			st_reg.en_pin    <= ~EN_ACTIVE_HIGH;
			st_reg.int_pin_n <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	assign power_en     = st_reg.en_pin;
	assign int_out_n    = 1'b0;
	assign int_oe_n     = st_reg.int_pin_n;
	assign power_on_sts = st_reg.en_act;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_blank_abort;
		@(posedge clk) disable iff (!rstn)
		(st_reg.state == pbs_pkg::PBS_BLANK && st_reg.tmr == '0 && kill_low)
		|=> !st_reg.en_act;
	endproperty
	a_blank_abort: assert property (p_blank_abort) else $error("abort missed");

	property p_kill_off;
		@(posedge clk) disable iff (!rstn)
		(st_reg.state == pbs_pkg::PBS_RUN && kill_low) |=> !st_reg.en_act && !st_reg.int_act;
	endproperty
	a_kill_off: assert property (p_kill_off) else $error("kill ignored");

	property p_blank_hold;
		@(posedge clk) disable iff (!rstn)
		(st_reg.state == pbs_pkg::PBS_BLANK && st_reg.tmr != '0) |=> st_reg.en_act;
	endproperty
	a_blank_hold: assert property (p_blank_hold) else $error("blank broken");

	property p_int_min;
		@(posedge clk) disable iff (!rstn)
		($rose(st_reg.int_act) && st_reg.state == pbs_pkg::PBS_RUN && !kill_low)
		|-> st_reg.tmr == pbs_pkg::DEB_TICKS;
	endproperty
	a_int_min: assert property (p_int_min) else $error("int timer wrong");

	property p_pol;
		@(posedge clk) disable iff (!rstn)
		power_en == (st_reg.en_act ^ ~EN_ACTIVE_HIGH);
	endproperty
	a_pol: assert property (p_pol) else $error("polarity wrong");

	property p_lock;
		@(posedge clk) disable iff (!rstn)
		(st_reg.state == pbs_pkg::PBS_LOCK && st_reg.tmr != '0) |=> !st_reg.en_act;
	endproperty
	a_lock: assert property (p_lock) else $error("lockout broken");

	property p_on_qual;
		@(posedge clk) disable iff (!rstn)
		$rose(st_reg.en_act) |-> $past(st_reg.low_cnt) >= pbs_pkg::DEB_TICKS;
	endproperty
	a_on_qual: assert property (p_on_qual) else $error("early enable");

	property p_restart;
		@(posedge clk) disable iff (!rstn)
		!btn_low |=> st_reg.low_cnt == '0;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart");

	sequence s_on_qual;
		st_reg.state == pbs_pkg::PBS_ARM && btn_low
		&& st_reg.low_cnt >= pbs_pkg::DEB_TICKS + on_delay_adjust;
	endsequence

	sequence s_blank_start;
		st_reg.state == pbs_pkg::PBS_BLANK && st_reg.en_act
		&& st_reg.tmr == pbs_pkg::BLANK_TICKS;
	endsequence

	property p_blank_enter;
		@(posedge clk) disable iff (!rstn)
		s_on_qual |=> s_blank_start;
	endproperty
	a_blank_enter: assert property (p_blank_enter) else $error("no power on");

	property p_arm_drop;
		@(posedge clk) disable iff (!rstn)
		(st_reg.state == pbs_pkg::PBS_ARM && !btn_low) |=> st_reg.state == pbs_pkg::PBS_OFF;
	endproperty
	a_arm_drop: assert property (p_arm_drop) else $error("arm not dropped");

	property p_off_idle;
		@(posedge clk) disable iff (!rstn)
		st_reg.state == pbs_pkg::PBS_OFF |-> !st_reg.en_act && !st_reg.int_act;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("off not idle");

	property p_sync;
		@(posedge clk) disable iff (!rstn)
		st_reg.btn_sync[1] == $past(button_in_n, 2);
	endproperty
	a_sync: assert property (p_sync) else $error("sync depth wrong");

	property p_run_enter;
		@(posedge clk) disable iff (!rstn)
		(st_reg.state == pbs_pkg::PBS_BLANK && st_reg.tmr == '0 && !kill_low)
		|=> st_reg.state == pbs_pkg::PBS_RUN && st_reg.en_act;
	endproperty
	a_run_enter: assert property (p_run_enter) else $error("run not entered");

	sequence s_int_qual;
		st_reg.state == pbs_pkg::PBS_RUN && !st_reg.int_act && btn_low && !kill_low
		&& st_reg.low_cnt >= pbs_pkg::DEB_TICKS
		&& st_reg.low_cnt < pbs_pkg::PD_TICKS + off_delay_adjust;
	endsequence

	property p_int_rise;
		@(posedge clk) disable iff (!rstn)
		s_int_qual |=> st_reg.int_act && !int_oe_n;
	endproperty
	a_int_rise: assert property (p_int_rise) else $error("int not raised");

	property p_int_hold;
		@(posedge clk) disable iff (!rstn)
		(st_reg.state == pbs_pkg::PBS_RUN && st_reg.int_act && st_reg.tmr != '0 && !kill_low
		&& !(btn_low && st_reg.low_cnt >= pbs_pkg::PD_TICKS + off_delay_adjust))
		|=> st_reg.int_act;
	endproperty
	a_int_hold: assert property (p_int_hold) else $error("int too short");

	property p_forced_off;
		@(posedge clk) disable iff (!rstn)
		(st_reg.state == pbs_pkg::PBS_RUN && !kill_low && btn_low
		&& st_reg.low_cnt >= pbs_pkg::PD_TICKS + off_delay_adjust)
		|=> !st_reg.en_act && !st_reg.int_act && st_reg.state == pbs_pkg::PBS_LOCK;
	endproperty
	a_forced_off: assert property (p_forced_off) else $error("no forced off");

	property p_kill_lock;
		@(posedge clk) disable iff (!rstn)
		(st_reg.state == pbs_pkg::PBS_RUN && kill_low)
		|=> st_reg.state == pbs_pkg::PBS_LOCK && st_reg.tmr == pbs_pkg::LOCK_TICKS;
	endproperty
	a_kill_lock: assert property (p_kill_lock) else $error("no lockout");

	property p_lock_stay;
		@(posedge clk) disable iff (!rstn)
		(st_reg.state == pbs_pkg::PBS_LOCK && btn_low) |=> st_reg.state == pbs_pkg::PBS_LOCK;
	endproperty
	a_lock_stay: assert property (p_lock_stay) else $error("lockout left early");
endmodule // pbs_sequencer

// ==== test/pbs_host.sv ====
`timescale 1ns/10ps
module pbs_host
#(
	parameter int BOOT = 200,
	parameter int HK   = 800
)
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       power_en,
	input  wire logic       int_n,
	input  wire logic [1:0] mode,
	output logic            kill_in_n
);
	int cnt;
	int hk;
	// Mode 1 never boots, mode 2 ignores the interrupt; an unpowered host pulls kill low
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn || !power_en)
		begin
			kill_in_n <= 1'h0;
			cnt       <= 0;
			hk        <= 0;
		end
		else
		begin
			cnt <= cnt + 1;
			if (cnt == BOOT && mode != 2'h1)
				kill_in_n <= 1'h1;
			if (hk != 0 || (!int_n && mode == 2'h0))
				hk <= hk + 1;
			if (hk == HK)
				kill_in_n <= 1'h0;
		end
	end
endmodule // pbs_host

// ==== test/push_button_power_sequencer_test.sv ====
`timescale 1ns/10ps
module push_button_power_sequencer_test;
	localparam int TC    = 2;
	localparam int DEB   = int'(pbs_pkg::DEB_TICKS);
	localparam int BLANK = int'(pbs_pkg::BLANK_TICKS);
	localparam int LOCK  = int'(pbs_pkg::LOCK_TICKS);
	localparam int PD    = int'(pbs_pkg::PD_TICKS);
	logic                      clk;
	logic                      rstn;
	logic                      button_in_n;
	logic                      kill_in_n;
	logic                      power_en;
	logic                      power_en_lo;
	logic                      int_out_n;
	logic                      int_oe_n;
	logic                      power_on_sts;
	logic                      int_wire;
	logic [1:0]                mode;
	logic [15:0]               seed;
	logic [pbs_pkg::CNT_W-1:0] on_adj;
	logic [pbs_pkg::CNT_W-1:0] off_adj;
	int                        n_mismatch;
	int                        comparisons;
	int                        t_on;
	int                        t_off;

	// Open-drain interrupt with pull-up
	assign int_wire = int_oe_n ? 1'h1 : int_out_n;

	pbs_sequencer #(.EN_ACTIVE_HIGH(1'h1), .TICK_CYCLES(TC)) dut
	(
		.clk              (clk),
		.rstn             (rstn),
		.button_in_n      (button_in_n),
		.kill_in_n        (kill_in_n),
		.on_delay_adjust  (on_adj),
		.off_delay_adjust (off_adj),
		.power_en         (power_en),
		.int_out_n        (int_out_n),
		.int_oe_n         (int_oe_n),
		.power_on_sts     (power_on_sts)
	);

	// Active-low enable variant, same stimulus
	pbs_sequencer #(.EN_ACTIVE_HIGH(1'h0), .TICK_CYCLES(TC)) dut_low
	(
		.clk              (clk),
		.rstn             (rstn),
		.button_in_n      (button_in_n),
		.kill_in_n        (kill_in_n),
		.on_delay_adjust  (on_adj),
		.off_delay_adjust (off_adj),
		.power_en         (power_en_lo),
		.int_out_n        (),
		.int_oe_n         (),
		.power_on_sts     ()
	);

	pbs_host #(.BOOT(100 * TC), .HK(400 * TC)) host
	(
		.clk       (clk),
		.rstn      (rstn),
		.power_en  (power_en),
		.int_n     (int_wire),
		.mode      (mode),
		.kill_in_n (kill_in_n)
	);

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic tk(input int n);
		repeat (n * TC) @(negedge clk);
	endtask

	task automatic chk(input string nm, input logic e, input logic g);
		comparisons++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("FAIL %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic outs(input logic s, input logic i);
		chk("power_on_sts", s, power_on_sts);
		chk("power_en", s, power_en);
		chk("power_en_lo", ~s, power_en_lo);
		chk("int", i, int_wire);
	endtask

	task automatic print_verdict;
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	initial
	begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		print_verdict;
	end

	initial
	begin
		rstn = 1'h0;
		button_in_n = 1'h1;
		mode = 2'h1;
		n_mismatch = 0;
		comparisons = 0;
		seed = lfsr(16'h2467);
		on_adj = pbs_pkg::CNT_W'(seed[4:0]);
		seed = lfsr(seed);
		off_adj = pbs_pkg::CNT_W'(seed[4:0]);
		t_on = DEB + int'(on_adj);
		t_off = PD + int'(off_adj);
		repeat (12) @(negedge clk);
		outs(1'h0, 1'h1);
		rstn = 1'h1;
		tk(4);
		outs(1'h0, 1'h1);
		button_in_n = 1'h0;
		tk(t_on - 20);
		button_in_n = 1'h1;
		tk(10);
		button_in_n = 1'h0;
		tk(t_on - 4);
		outs(1'h0, 1'h1);
		tk(8);
		outs(1'h1, 1'h1);
		button_in_n = 1'h1;
		tk(BLANK - 20);
		outs(1'h1, 1'h1);
		tk(24);
		outs(1'h0, 1'h1);
		mode = 2'h0;
		button_in_n = 1'h0;
		tk(t_on + 4);
		outs(1'h1, 1'h1);
		tk(t_off + 40);
		button_in_n = 1'h1;
		outs(1'h1, 1'h1);
		tk(BLANK);
		outs(1'h1, 1'h1);
		button_in_n = 1'h0;
		tk(DEB - 4);
		outs(1'h1, 1'h1);
		tk(8);
		outs(1'h1, 1'h0);
		button_in_n = 1'h1;
		tk(DEB - 12);
		outs(1'h1, 1'h0);
		tk(20);
		outs(1'h1, 1'h1);
		tk(80);
		outs(1'h0, 1'h1);
		button_in_n = 1'h0;
		tk(t_on + 40);
		outs(1'h0, 1'h1);
		button_in_n = 1'h1;
		tk(LOCK);
		mode = 2'h2;
		button_in_n = 1'h0;
		tk(t_on + 4);
		outs(1'h1, 1'h1);
		button_in_n = 1'h1;
		tk(BLANK + 20);
		button_in_n = 1'h0;
		tk(t_off - 4);
		outs(1'h1, 1'h0);
		tk(8);
		outs(1'h0, 1'h1);
		button_in_n = 1'h1;
		print_verdict;
	end
endmodule // push_button_power_sequencer_test
